/* File: common/scp_pkg.sv */
// Constants and types shared by the serial control port files.
// Assumes a 13-bit register space and a 16-bit instruction word.
package scp_pkg;

   // ****************************************************************
   // Instruction word layout
   // ****************************************************************
   localparam int INSTR_W     = 16;
   localparam int ADDR_W      = 13;
   localparam int RW_BIT      = 15;
   localparam int CODE_HI_BIT = 14;
   localparam int CODE_LO_BIT = 13;
   localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
   localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;
   localparam logic [2:0] BYTE_FIRST_BIT = 3'h0;

   // ****************************************************************
   // Byte-count codes
   // ****************************************************************
   localparam logic [1:0] CNT_ONE    = 2'h0;
   localparam logic [1:0] CNT_TWO    = 2'h1;
   localparam logic [1:0] CNT_THREE  = 2'h2;
   localparam logic [1:0] CNT_STREAM = 2'h3;

   // ****************************************************************
   // Register offsets, field positions, reset values
   // ****************************************************************
   localparam logic [12:0] ADDR_PORT_CONFIG = 13'h0000;
   localparam logic [12:0] ADDR_READBACK    = 13'h0004;
   localparam logic [12:0] ADDR_UPDATE      = 13'h0005;
   localparam logic [12:0] ADDR_LOWEST      = 13'h0000;
   localparam logic [12:0] ADDR_HIGHEST     = 13'h1FFF;
   localparam int LSB_FIRST_BIT = 6;
   localparam int FOUR_WIRE_BIT = 7;
   localparam int READBACK_BIT  = 0;
   localparam int UPDATE_BIT    = 0;
   localparam logic RST_LSB_FIRST = 1'h0;
   localparam logic RST_FOUR_WIRE = 1'h0;
   localparam logic RST_RB_ACTIVE = 1'h0;

   // ****************************************************************
   // Link state machine
   // ****************************************************************
   typedef enum logic [4:0] {
      SCP_IDLE  = 5'h01,
      SCP_INSTR = 5'h02,
      SCP_WRITE = 5'h04,
      SCP_READ  = 5'h08,
      SCP_DONE  = 5'h10
   } scp_state_e;

endpackage

/* File: hw/scp_sync.sv */
// Two-stage level synchroniser.
// Assumes the input is a level that stays put for several clocks.
`timescale 1ns/1ps
module scp_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Level in and out
   input  wire logic d_in,
   output logic      d_out
);

   typedef struct packed {
      logic s1;
      logic s2;
   } scp_sync_s;

   scp_sync_s r_reg;
   scp_sync_s r_next;

   always_comb begin
      r_next    = r_reg;
      r_next.s1 = d_in;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign d_out = r_reg.s2;

endmodule // scp_sync

/* File: hw/scp_active_bank.sv */
// Active register bank on the core clock, loaded from the buffer copy.
// Assumes the buffer copy is quiet while an update is being taken.
`timescale 1ns/1ps
module scp_active_bank #(
   parameter int NREG = 32
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // Update sources, synchronised except the pin enable
   input  wire logic              upd_tog_sync,
   input  wire logic              pin_sync,
   input  wire logic              pin_en,
   // Register contents
   input  wire logic [NREG*8-1:0] buffer_regs,
   output logic      [NREG*8-1:0] active_regs,
   output logic                   update_pulse
);

   typedef struct packed {
      logic              prev_tog;
      logic              prev_pin;
      logic              pulse;
      logic [NREG*8-1:0] active;
   } scp_bank_s;

   scp_bank_s r_reg;
   scp_bank_s r_next;

   always_comb begin
      r_next          = r_reg;
      r_next.prev_tog = upd_tog_sync;
      r_next.prev_pin = pin_sync;
      r_next.pulse    = (upd_tog_sync != r_reg.prev_tog)
                      | (pin_en & pin_sync & ~r_reg.prev_pin);
      // Whole bank moves at once, never a partial copy
      if (r_next.pulse) begin
         r_next.active = buffer_regs;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign active_regs  = r_reg.active;
   assign update_pulse = r_reg.pulse;

endmodule // scp_active_bank

/* File: hw/scp_spi_port.sv */
// Serial control port slave: instruction decode, buffered writes, readback.
// Assumes the host drives sclk idle low, changes data on the falling edge,
// and that sclk stands still while cs_n is high.
`timescale 1ns/1ps
module scp_spi_port #(
   parameter int NREG = 32
) (
   // Core clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // Serial link
   input  wire logic              sclk,
   input  wire logic              cs_n,
   input  wire logic              sdio_i,
   output logic                   sdio_o,
   output logic                   sdio_oe_n,
   output logic                   sdo_o,
   output logic                   sdo_oe_n,
   // Multifunction update pin
   input  wire logic              mfp_update_pin,
   input  wire logic              mfp_update_en,
   // Device side
   output logic      [NREG*8-1:0] active_regs,
   output logic                   update_pulse
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // Fewer than six entries would not reach the update register
   generate
      if (NREG < 6 || NREG > 8192) begin : g_bad_nreg
         $error("scp_spi_port: NREG must lie between 6 and 8192");
      end
   endgenerate

   localparam logic [13:0] NREG_L = 14'(NREG);

   // ****************************************************************
   // Link state, rising edge of sclk
   // ****************************************************************
   typedef struct packed {
      scp_pkg::scp_state_e   state;
      logic [3:0]            bit_cnt;
      logic [15:0]           shift;
      logic                  rd;
      logic [1:0]            count_code;
      logic [1:0]            bytes_done;
      logic [12:0]           addr;
      logic                  op_lsb;
      logic                  lsb_first;
      logic                  four_wire;
      logic                  rb_active;
      logic                  upd_tog;
      logic                  end_ack;
      logic [NREG-1:0][7:0]  buffer;
   } scp_link_s;

   // Output stage, falling edge of sclk
   typedef struct packed {
      logic       out_bit;
      logic       drive;
      logic [7:0] out_shift;
   } scp_out_s;

   // Frame end bookkeeping, rising edge of cs_n
   typedef struct packed {
      logic end_req;
   } scp_frame_s;

   scp_link_s  l_reg;
   scp_link_s  l_next;
   scp_out_s   o_reg;
   scp_out_s   o_next;
   scp_frame_s f_reg;
   scp_frame_s f_next;

   logic              restart;
   logic              stream;
   logic              last_byte;
   logic              at_end;
   logic              end_cond;
   logic [15:0]       instr_word;
   logic [7:0]        wr_byte;
   logic [7:0]        rd_byte;
   logic [NREG*8-1:0] buffer_flat;
   logic              upd_tog_sync;
   logic              pin_sync;
   logic              out_ok;

   assign buffer_flat = l_reg.buffer;
   assign stream      = (l_reg.count_code == scp_pkg::CNT_STREAM);

   // ****************************************************************
   // Frame end capture
   // ****************************************************************
   // Clocked by the frame signal itself, since sclk may stop when
   // cs_n rises; a stall on a byte boundary before the last byte of a counted transfer leaves no request behind.
   always_comb begin
      end_cond = (l_reg.state != scp_pkg::SCP_IDLE)
               && ((l_reg.bit_cnt[2:0] != scp_pkg::BYTE_FIRST_BIT)
                   || stream
                   || (l_reg.state == scp_pkg::SCP_DONE));
      f_next = f_reg;
      if (end_cond) begin
         f_next.end_req = ~l_reg.end_ack;
      end
   end

   always_ff @(posedge cs_n or posedge rst) begin
      if (rst) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   assign restart = (f_reg.end_req != l_reg.end_ack);

   // ****************************************************************
   // Bit assembly
   // ****************************************************************
   always_comb begin
      if (l_reg.lsb_first) begin
         instr_word = {sdio_i, l_reg.shift[15:1]};
      end else begin
         instr_word = {l_reg.shift[14:0], sdio_i};
      end
      if (l_reg.op_lsb) begin
         wr_byte = {sdio_i, l_reg.shift[7:1]};
      end else begin
         wr_byte = {l_reg.shift[6:0], sdio_i};
      end
   end

   // ****************************************************************
   // Address sequencing
   // ****************************************************************
   always_comb begin
      last_byte = !stream && (l_reg.bytes_done == l_reg.count_code);
      if (l_reg.op_lsb) begin
         at_end = (l_reg.addr == scp_pkg::ADDR_HIGHEST);
      end else begin
         at_end = (l_reg.addr == scp_pkg::ADDR_LOWEST);
      end
   end

   // ****************************************************************
   // Link state machine
   // ****************************************************************
   always_comb begin
      scp_pkg::scp_state_e cur;
      logic                byte_done;
      cur       = l_reg.state;
      byte_done = 1'h0;
      l_next    = l_reg;
      if (!cs_n) begin
         l_next.end_ack = f_reg.end_req;
         if (restart) begin
            cur = scp_pkg::SCP_IDLE;
         end
         case (cur)
            scp_pkg::SCP_IDLE: begin
               l_next.shift   = instr_word;
               l_next.bit_cnt = 4'h1;
               l_next.state   = scp_pkg::SCP_INSTR;
            end
            scp_pkg::SCP_INSTR: begin
               l_next.shift   = instr_word;
               l_next.bit_cnt = 4'(l_reg.bit_cnt + 4'h1);
               if (l_reg.bit_cnt == scp_pkg::INSTR_LAST_BIT) begin
                  l_next.rd         = instr_word[scp_pkg::RW_BIT];
                  l_next.count_code = {instr_word[scp_pkg::CODE_HI_BIT],
                                       instr_word[scp_pkg::CODE_LO_BIT]};
                  l_next.addr       = instr_word[12:0];
                  l_next.bytes_done = 2'h0;
                  l_next.bit_cnt    = 4'h0;
                  l_next.op_lsb     = l_reg.lsb_first;
                  if (instr_word[scp_pkg::RW_BIT]) begin
                     l_next.state = scp_pkg::SCP_READ;
                  end else begin
                     l_next.state = scp_pkg::SCP_WRITE;
                  end
               end
            end
            scp_pkg::SCP_WRITE: begin
               l_next.shift   = {8'h00, wr_byte};
               l_next.bit_cnt = {1'h0, 3'(l_reg.bit_cnt[2:0] + 3'h1)};
               if (l_reg.bit_cnt[2:0] == scp_pkg::BYTE_LAST_BIT) begin
                  byte_done = 1'h1;
                  case (l_reg.addr)
                     scp_pkg::ADDR_PORT_CONFIG: begin
                        l_next.lsb_first = wr_byte[scp_pkg::LSB_FIRST_BIT];
                        l_next.four_wire = wr_byte[scp_pkg::FOUR_WIRE_BIT];
                     end
                     scp_pkg::ADDR_READBACK: begin
                        l_next.rb_active = wr_byte[scp_pkg::READBACK_BIT];
                     end
                     scp_pkg::ADDR_UPDATE: begin
                        // Stored as an event, so the bit always reads back 0
                        if (wr_byte[scp_pkg::UPDATE_BIT]) begin
                           l_next.upd_tog = ~l_reg.upd_tog;
                        end
                     end
                     default: begin
                        // Unmapped addresses still consume their byte
                        if ({1'h0, l_reg.addr} < NREG_L) begin
                           l_next.buffer[l_reg.addr] = wr_byte;
                        end
                     end
                  endcase
               end
            end
            scp_pkg::SCP_READ: begin
               l_next.bit_cnt = {1'h0, 3'(l_reg.bit_cnt[2:0] + 3'h1)};
               if (l_reg.bit_cnt[2:0] == scp_pkg::BYTE_LAST_BIT) begin
                  byte_done = 1'h1;
               end
            end
            scp_pkg::SCP_DONE: begin
               // Extra bits are ignored until the frame ends
               l_next.state = scp_pkg::SCP_DONE;
            end
            default: begin
               l_next.state = scp_pkg::SCP_IDLE;
            end
         endcase
         if (byte_done) begin
            if (last_byte || at_end) begin
               l_next.state = scp_pkg::SCP_DONE;
            end else begin
               if (!stream) begin
                  l_next.bytes_done = 2'(l_reg.bytes_done + 2'h1);
               end
               if (l_reg.op_lsb) begin
                  l_next.addr = 13'(l_reg.addr + 13'h0001);
               end else begin
                  l_next.addr = 13'(l_reg.addr - 13'h0001);
               end
            end
         end
      end
   end

   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         l_reg           <= '0;
         l_reg.state     <= scp_pkg::SCP_IDLE;
         l_reg.lsb_first <= scp_pkg::RST_LSB_FIRST;
         l_reg.four_wire <= scp_pkg::RST_FOUR_WIRE;
         l_reg.rb_active <= scp_pkg::RST_RB_ACTIVE;
      end else begin
         l_reg <= l_next;
      end
   end

   // ****************************************************************
   // Readback fetch
   // ****************************************************************
   // Active copy changes only on an update; reads racing one may mix
   always_comb begin
      case (l_reg.addr)
         scp_pkg::ADDR_PORT_CONFIG: begin
            rd_byte = {l_reg.four_wire, l_reg.lsb_first, 6'h00};
         end
         scp_pkg::ADDR_READBACK: begin
            rd_byte = {7'h00, l_reg.rb_active};
         end
         scp_pkg::ADDR_UPDATE: begin
            rd_byte = 8'h00;
         end
         default: begin
            if ({1'h0, l_reg.addr} >= NREG_L) begin
               rd_byte = 8'h00;
            end else if (l_reg.rb_active) begin
               rd_byte = active_regs[l_reg.addr*8 +: 8];
            end else begin
               rd_byte = l_reg.buffer[l_reg.addr];
            end
         end
      endcase
   end

   // ****************************************************************
   // Output stage
   // ****************************************************************
   // Bits change on the falling edge so they stand across the next rise
   always_comb begin
      o_next = o_reg;
      if (!cs_n) begin
         if (l_reg.state == scp_pkg::SCP_READ && !restart) begin
            o_next.drive = 1'h1;
            if (l_reg.bit_cnt[2:0] == scp_pkg::BYTE_FIRST_BIT) begin
               if (l_reg.op_lsb) begin
                  o_next.out_bit   = rd_byte[0];
                  o_next.out_shift = {1'h0, rd_byte[7:1]};
               end else begin
                  o_next.out_bit   = rd_byte[7];
                  o_next.out_shift = {rd_byte[6:0], 1'h0};
               end
            end else begin
               if (l_reg.op_lsb) begin
                  o_next.out_bit   = o_reg.out_shift[0];
                  o_next.out_shift = {1'h0, o_reg.out_shift[7:1]};
               end else begin
                  o_next.out_bit   = o_reg.out_shift[7];
                  o_next.out_shift = {o_reg.out_shift[6:0], 1'h0};
               end
            end
         end else begin
            o_next.drive = 1'h0;
         end
      end
   end

   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         o_reg <= '0;
      end else begin
         o_reg <= o_next;
      end
   end

   assign sdio_o    = o_reg.out_bit;
   assign sdo_o     = o_reg.out_bit;
   // Stale drive left by a cut read must not fight the next instruction
   assign out_ok    = !restart && (l_reg.state != scp_pkg::SCP_INSTR);
   assign sdio_oe_n = cs_n | ~o_reg.drive | ~out_ok | l_reg.four_wire;
   assign sdo_oe_n  = cs_n | ~o_reg.drive | ~out_ok | ~l_reg.four_wire;

   // ****************************************************************
   // Crossings into the core clock
   // ****************************************************************
   scp_sync u_sync_upd (
      .clk   (core_clk),
      .rst   (rst),
      .d_in  (l_reg.upd_tog),
      .d_out (upd_tog_sync)
   );

   scp_sync u_sync_pin (
      .clk   (core_clk),
      .rst   (rst),
      .d_in  (mfp_update_pin),
      .d_out (pin_sync)
   );

   // ****************************************************************
   // Active bank
   // ****************************************************************
   scp_active_bank #(
      .NREG (NREG)
   ) u_bank (
      .core_clk     (core_clk),
      .rst          (rst),
      .upd_tog_sync (upd_tog_sync),
      .pin_sync     (pin_sync),
      .pin_en       (mfp_update_en),
      .buffer_regs  (buffer_flat),
      .active_regs  (active_regs),
      .update_pulse (update_pulse)
   );

endmodule // scp_spi_port

/* File: test/scp_spi_properties.sv */
// Checker for the serial control port top ports.
// Assumes core_clk domain for update logic, sclk for the link.
`timescale 1ns/1ps
module scp_spi_checker #(
   parameter int NREG = 32
) (
   // Clocks and reset
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              sclk,
   // Link
   input wire logic              cs_n,
   input wire logic              sdio_i,
   input wire logic              sdio_o,
   input wire logic              sdio_oe_n,
   input wire logic              sdo_o,
   input wire logic              sdo_oe_n,
   // Update and device side
   input wire logic              mfp_update_pin,
   input wire logic              mfp_update_en,
   input wire logic [NREG*8-1:0] active_regs,
   input wire logic              update_pulse
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   AST_PULSE_ONE: assert property (@(posedge core_clk) disable iff (rst)
      update_pulse |=> !update_pulse) else $error("update pulse too long");
   AST_ACT_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      !update_pulse |-> $stable(active_regs)) else $error("active moved");
   AST_ZERO: assert property (@(posedge core_clk) disable iff (rst)
      active_regs[47:32] == 16'h0000) else $error("update bit kept");
   AST_HIZ: assert property (@(posedge core_clk) disable iff (rst)
      cs_n |-> sdio_oe_n && sdo_oe_n) else $error("driven while deselected");
   AST_ONE_PIN: assert property (@(posedge core_clk) disable iff (rst)
      sdio_oe_n || sdo_oe_n) else $error("both outputs on");
   AST_SAME: assert property (@(posedge sclk) disable iff (rst)
      !sdio_oe_n |-> sdo_o == sdio_o) else $error("outputs differ");
   AST_PIN: assert property (@(posedge core_clk) disable iff (rst)
      $rose(mfp_update_pin) && mfp_update_en |-> ##[1:8] update_pulse)
      else $error("pin update lost");
   AST_DRV: assert property (@(negedge sclk) disable iff (rst)
      $fell(sdio_oe_n) |-> !cs_n ##1 (!cs_n || sdio_oe_n)) else $error("bad drive");
endmodule // scp_spi_checker
bind scp_spi_port scp_spi_checker #(.NREG(NREG)) u_chk (.core_clk(core_clk), .rst(rst),
   .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n),
   .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .mfp_update_pin(mfp_update_pin),
   .mfp_update_en(mfp_update_en), .active_regs(active_regs), .update_pulse(update_pulse));

/* File: test/scp_host_model.sv */
// Host side model: drives serial clock, select and data.
// Handles 3-wire and 4-wire wiring; sclk idles low and stops between frames.
`timescale 1ns/1ps
module scp_host_model (
   // Serial link
   output logic      sclk,
   output logic      cs_n,
   output logic      sdio_i,
   input  wire logic sdio_o,
   input  wire logic sdio_oe_n,
   input  wire logic sdo_o,
   input  wire logic sdo_oe_n
);
   logic drv;
   logic sdo_line;
   // Released output line shows the inverse of its last bit
   assign sdo_line = sdo_oe_n ? ~sdo_o : sdo_o;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      drv = 1'b0;
   end
   // Shared wire: device wins when it drives
   assign sdio_i = sdio_oe_n ? drv : sdio_o;
   task automatic sel(input logic v);
      #20 cs_n = v;
      #20;
   endtask
   // Sends bits n-1..0 of v, capture on each rise
   task automatic shift(input logic [31:0] v, input int n, output logic [31:0] r);
      r = '0;
      for (int i = n - 1; i >= 0; i--) begin
         drv = v[i];
         #7.5 sclk = 1'b1;
         r = {r[30:0], sdio_oe_n ? sdo_line : sdio_i};
         #7.5 sclk = 1'b0;
      end
      drv = ~drv; // Released data shows no stale level
   endtask
endmodule // scp_host_model

/* File: test/tb.sv */
// Testbench for the serial control port.
// Assumes the host model in scp_host_model and NREG of 32.
`timescale 1ns/1ps
module tb;
   logic              core_clk, rst, mfp_update_pin, mfp_update_en, lsb;
   logic              sclk, cs_n, sdio_i, sdio_o, sdio_oe_n, sdo_o, sdo_oe_n;
   logic              update_pulse;
   logic [255:0]      active_regs;
   logic [23:0]       rd;
   logic [31:0]       x;
   int                fail_count, checks, n;
   scp_spi_port #(.NREG(32)) u_dut (.core_clk(core_clk), .rst(rst), .sclk(sclk),
      .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .sdo_o(sdo_o),
      .sdo_oe_n(sdo_oe_n), .mfp_update_pin(mfp_update_pin), .mfp_update_en(mfp_update_en),
      .active_regs(active_regs), .update_pulse(update_pulse));
   scp_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
      .sdio_oe_n(sdio_oe_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] e);
      checks++;
      if (seen !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", s, e, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   function automatic logic [31:0] flip(input logic [31:0] v, input int n);
      flip = '0;
      for (int i = 0; i < n; i++) flip[i] = v[n-1-i];
   endfunction
   // One frame: instruction then n bytes, optional stall per byte
   task automatic xfer(input logic w, input logic [1:0] c, input logic [12:0] a,
                       input int n, input logic [23:0] d, input bit st);
      logic [31:0] ins;
      ins = {16'h0000, w, c, a};
      u_host.sel(1'b0);
      u_host.shift(lsb ? flip(ins, 16) : ins, 16, x);
      rd = '0;
      for (int i = 0; i < n; i++) begin
         if (st) begin
            u_host.sel(1'b1);
            u_host.sel(1'b0);
         end
         u_host.shift(lsb ? flip(32'(d[8*i+:8]), 8) : 32'(d[8*i+:8]), 8, x);
         rd[8*i+:8] = lsb ? flip(x, 8) : x[7:0];
      end
      u_host.sel(1'b1);
   endtask
   task automatic wait_upd();
      for (int i = 0; i < 20; i++) begin
         @(negedge core_clk);
         if (update_pulse === 1'b1) return;
      end
      fail_count++;
      close_out();
   endtask
   initial begin
      {rst, mfp_update_pin, mfp_update_en, lsb, fail_count, checks} = '0;
      rst = 1'b1;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      check("oe", {sdio_oe_n, sdo_oe_n, active_regs === '0}, 3'h7);
      xfer(1, 2'h0, 13'h0000, 1, 0, 0);
      check("cfg", rd, 24'h0);
      xfer(0, 2'h2, 13'h0012, 3, 24'h332211, 1);
      xfer(1, 2'h2, 13'h0012, 3, 0, 1);
      check("rd3", rd, 24'h332211);
      check("hold", active_regs[128+:24], 24'h0);
      for (int c = 0; c < 4; c++) begin
         xfer(0, 2'h3, 13'h000A, 3, 0, 0);
         xfer(0, 2'(c), 13'h000A, 3, 24'hC3B2A1, 0);
         xfer(1, 2'h3, 13'h000A, 3, 0, 0);
         check("count", rd, c == 0 ? 24'hA1 : c == 1 ? 24'hB2A1 : 24'hC3B2A1);
      end
      u_host.sel(1'b0);
      u_host.shift(32'h000A, 16, x);
      u_host.shift(32'hF, 4, x);
      u_host.sel(1'b1);
      xfer(1, 2'h0, 13'h000A, 1, 0, 0);
      check("abort", rd, 24'hA1);
      xfer(0, 2'h0, 13'h0000, 1, 24'h40, 0);
      lsb = 1'b1;
      xfer(0, 2'h1, 13'h0014, 2, 24'h6655, 1);
      xfer(1, 2'h1, 13'h0014, 2, 0, 0);
      check("lsb", rd, 24'h6655);
      xfer(0, 2'h0, 13'h0000, 1, 0, 0);
      lsb = 1'b0;
      xfer(1, 2'h0, 13'h0015, 1, 0, 0);
      check("msb", rd, 24'h66);
      xfer(0, 2'h1, 13'h0020, 2, 24'h7E00, 0);
      xfer(1, 2'h1, 13'h0020, 2, 0, 0);
      check("blank", rd, 24'h7E00);
      xfer(0, 2'h0, 13'h0004, 1, 24'h1, 0);
      xfer(1, 2'h0, 13'h0012, 1, 0, 0);
      check("rb", rd, 24'h0);
      xfer(0, 2'h0, 13'h0005, 1, 24'h1, 0);
      wait_upd();
      check("upd", active_regs[128+:24], 24'h112233);
      xfer(1, 2'h0, 13'h0005, 1, 0, 0);
      check("clr", rd, 24'h0);
      xfer(0, 2'h0, 13'h0012, 1, 24'h5A, 0);
      @(posedge core_clk);
      mfp_update_en <= 1'b1;
      @(posedge core_clk);
      mfp_update_pin <= 1'b1;
      wait_upd();
      check("pin", active_regs[144+:8], 8'h5A);
      @(posedge core_clk);
      {mfp_update_en, mfp_update_pin} <= 2'h0;
      xfer(0, 2'h0, 13'h0012, 1, 24'h77, 0);
      @(posedge core_clk);
      mfp_update_pin <= 1'b1;
      n = 0;
      repeat (10) begin
         @(negedge core_clk);
         if (update_pulse !== 1'b0) n++;
      end
      check("pin_off", n, 0);
      check("keep", active_regs[144+:8], 8'h5A);
      xfer(0, 2'h0, 13'h0000, 1, 24'h80, 0);
      xfer(1, 2'h0, 13'h0000, 1, 0, 0);
      check("four", rd, 24'h80);
      @(posedge core_clk);
      mfp_update_pin <= 1'b0;
      rst <= 1'b1;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      check("oe2", {sdio_oe_n, sdo_oe_n, active_regs === '0}, 3'h7);
      xfer(1, 2'h0, 13'h0012, 1, 0, 0);
      check("rst", rd, 24'h0);
      xfer(1, 2'h0, 13'h0000, 1, 0, 0);
      check("cfg2", rd, 24'h0);
      close_out();
   end
endmodule // tb
